// ==== rtl/aalu_pkg.sv ====
// Package for the accumulator ALU datapath: operation codes, widths, cycle and byte counts.
// Assumes one 24-bit processor clock domain shared with the instruction sequencer.
package aalu_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int AALU_W          = 24;
    localparam int AALU_FRAC_SHIFT = 24;
    localparam int AALU_NREG       = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Operation codes seen on op_code
    typedef enum logic [2:0] {
        AALU_OP_COMPL  = 3'h0,
        AALU_OP_DECR   = 3'h1,
        AALU_OP_DECPTR = 3'h2,
        AALU_OP_FDIV   = 3'h3,
        AALU_OP_DIVMOD = 3'h4,
        AALU_OP_XOR    = 3'h5,
        AALU_OP_XNOR   = 3'h6
    } aalu_op_t;

    localparam logic [2:0] AALU_OP_LAST = 3'h6;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts
    localparam logic [4:0] AALU_CYC_COMPL   = 5'h02;
    localparam logic [4:0] AALU_CYC_DECR    = 5'h01;
    localparam logic [4:0] AALU_CYC_DECPTR  = 5'h01;
    localparam logic [4:0] AALU_CYC_FDIV    = 5'h14;
    localparam logic [4:0] AALU_CYC_DIVMOD  = 5'h14;
    localparam logic [4:0] AALU_CYC_LOG_REG = 5'h03;
    localparam logic [4:0] AALU_CYC_LOG_IMM = 5'h06;

    // Encoding lengths in bytes
    localparam logic [2:0] AALU_BYT_COMPL   = 3'h2;
    localparam logic [2:0] AALU_BYT_DECR    = 3'h1;
    localparam logic [2:0] AALU_BYT_DECPTR  = 3'h1;
    localparam logic [2:0] AALU_BYT_DIV     = 3'h2;
    localparam logic [2:0] AALU_BYT_LOG_REG = 3'h2;
    localparam logic [2:0] AALU_BYT_LOG_IMM = 3'h5;

    function automatic logic [4:0] aalu_cycles(input aalu_op_t op, input logic imm);
        logic [4:0] c;
        c = AALU_CYC_DECR;
        unique case (op)
            AALU_OP_COMPL:  c = AALU_CYC_COMPL;
            AALU_OP_DECR:   c = AALU_CYC_DECR;
            AALU_OP_DECPTR: c = AALU_CYC_DECPTR;
            AALU_OP_FDIV:   c = AALU_CYC_FDIV;
            AALU_OP_DIVMOD: c = AALU_CYC_DIVMOD;
            AALU_OP_XOR, AALU_OP_XNOR: c = imm ? AALU_CYC_LOG_IMM : AALU_CYC_LOG_REG;
        endcase
        return c;
    endfunction : aalu_cycles

    function automatic logic [2:0] aalu_bytes(input aalu_op_t op, input logic imm);
        logic [2:0] b;
        b = AALU_BYT_DECR;
        unique case (op)
            AALU_OP_COMPL:  b = AALU_BYT_COMPL;
            AALU_OP_DECR:   b = AALU_BYT_DECR;
            AALU_OP_DECPTR: b = AALU_BYT_DECPTR;
            AALU_OP_FDIV, AALU_OP_DIVMOD: b = AALU_BYT_DIV;
            AALU_OP_XOR, AALU_OP_XNOR: b = imm ? AALU_BYT_LOG_IMM : AALU_BYT_LOG_REG;
        endcase
        return b;
    endfunction : aalu_bytes

endpackage : aalu_pkg

// ==== rtl/aalu_sdiv.sv ====
// Combinational signed divider shared by both division operations.
// Assumes the caller holds its operands stable for the whole multi-cycle operation.
`timescale 1ns/10ps
`default_nettype none
module aalu_sdiv
    import aalu_pkg::*;
(
    // Operands
    input  wire logic [2*AALU_W-1:0] dividend,
    input  wire logic [AALU_W-1:0]   divisor,
    // Results
    output logic      [AALU_W-1:0]   quotient,
    output logic      [AALU_W-1:0]   remainder
);

    logic signed [2*AALU_W-1:0] sdivisor;
    logic signed [2*AALU_W-1:0] q_full;
    logic signed [2*AALU_W-1:0] r_full;

    always_comb begin
        sdivisor = {{AALU_W{divisor[AALU_W-1]}}, divisor};
        // Zero divisor gives quotient zero rather than an undefined value
        if (divisor == '0) begin
            q_full = '0;
            r_full = $signed(dividend);
        end else begin
            q_full = $signed(dividend) / sdivisor;
            r_full = $signed(dividend) % sdivisor;
        end
        quotient  = q_full[AALU_W-1:0];
        remainder = r_full[AALU_W-1:0];
    end

endmodule : aalu_sdiv
`default_nettype wire

// ==== rtl/aalu_core.sv ====
// Accumulator ALU datapath: complement, decrement, pointer decrement, two divisions, XOR and XNOR.
// Assumes the sequencer presents one operation at a time and waits while busy is high.
//
// Summary of operation
// RULE1: Complement replaces the chosen working register by its inverse plus one, sets only sign and zero, 2 cycles.
// RULE2: Decrement subtracts one from the chosen working register in one cycle and sets carry, overflow, sign, zero.
// RULE3: Pointer decrement lowers the RAM address pointer by one in one cycle and leaves all flags alone.
// RULE4: Fractional divide writes (first shifted left 24) over second, signed, sets sign and zero, 20 cycles.
// RULE5: Signed quotient/remainder puts the quotient in the first register and the remainder in the second.
// RULE6: XOR writes a one where the operands differ into the first register and sets sign and zero.
// RULE7: XOR takes a register operand in 3 cycles (2 bytes) or a 24-bit immediate in 6 cycles (5 bytes).
// RULE8: XNOR writes a one where the operands match into the first register and sets sign and zero.
// RULE9: XNOR takes a register operand in 3 cycles (2 bytes) or a 24-bit immediate in 6 cycles (5 bytes).
// RULE10: Destination and divisor are each selected among the four working registers.
`timescale 1ns/10ps
`default_nettype none
module aalu_core
    import aalu_pkg::*;
#(
    parameter int PTR_W = 8
)(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    // Operation request
    input  wire logic                          op_valid,
    input  wire logic [2:0]                    op_code,
    input  wire logic [1:0]                    dst_sel,
    input  wire logic [1:0]                    src_sel,
    input  wire logic                          imm_sel,
    input  wire logic [AALU_W-1:0]             imm_data,
    // Completion
    output logic                               busy,
    output logic                               done,
    output logic [2:0]                         op_bytes,
    // Architectural state
    output logic [AALU_NREG-1:0][AALU_W-1:0]   working_register,
    output logic [PTR_W-1:0]                   ram_pointer,
    output logic                               flag_sign,
    output logic                               flag_zero,
    output logic                               flag_carry,
    output logic                               flag_overflow
);

    // Elaboration-time range check on the pointer width
    if (PTR_W < 1 || PTR_W > 16) begin : g_bad_ptr_w
        $error("PTR_W out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef enum logic {AALU_IDLE, AALU_RUN} aalu_state_t;

    aalu_state_t                        state, next_state;
    aalu_op_t                           op_q, next_op_q;
    logic [1:0]                         dst_q, next_dst_q;
    logic [1:0]                         src_q, next_src_q;
    logic                               imm_q, next_imm_q;
    logic [AALU_W-1:0]                  b_q, next_b_q;
    logic [4:0]                         cnt, next_cnt;
    logic                               next_busy, next_done;
    logic [2:0]                         next_op_bytes;
    logic [AALU_NREG-1:0][AALU_W-1:0]   next_working_register;
    logic [PTR_W-1:0]                   next_ram_pointer;
    logic                               next_flag_sign, next_flag_zero;
    logic                               next_flag_carry, next_flag_overflow;

    // Datapath temporaries
    aalu_op_t                           cur_op;
    logic [1:0]                         cur_dst, cur_src;
    logic                               cur_imm;
    logic [AALU_W-1:0]                  cur_a, cur_b, res;
    logic [4:0]                         cyc;
    logic                               accept, finish;
    logic [2*AALU_W-1:0]                div_num;
    logic [AALU_W-1:0]                  div_q, div_r;

    ////////////////////////////////////////////////////////////////////////////
    // Shared divider; operands come from held registers, so a 20-cycle budget
    // covers the long combinational path as a multicycle path
    aalu_sdiv u_sdiv (
        .dividend  (div_num),
        .divisor   (cur_b),
        .quotient  (div_q),
        .remainder (div_r)
    );

    always_comb begin
        accept  = op_valid && (state == AALU_IDLE) && (op_code <= AALU_OP_LAST);
        // Code 7 is refused; map it to a legal code so the cycle table never sees it
        cur_op  = (state == AALU_RUN) ? op_q :
                  ((op_code <= AALU_OP_LAST) ? aalu_op_t'(op_code) : AALU_OP_DECR);
        cur_dst = (state == AALU_RUN) ? dst_q : dst_sel;
        cur_src = (state == AALU_RUN) ? src_q : src_sel;
        cur_imm = (state == AALU_RUN) ? imm_q : imm_sel;
        // Divisor always from a register, logic operand from register or immediate
        cur_b   = (state == AALU_RUN) ? b_q :
                  ((imm_sel && (cur_op == AALU_OP_XOR || cur_op == AALU_OP_XNOR)) ?
                   imm_data : working_register[src_sel]);                               // [RULE10]
        cur_a   = working_register[cur_dst];                                            // [RULE10]
        cyc     = aalu_cycles(cur_op, cur_imm);                                         // [RULE7] [RULE9]
        finish  = (accept && cyc == 5'h01) || (state == AALU_RUN && cnt == 5'h01);
        if (cur_op == AALU_OP_FDIV) begin
            div_num = {cur_a, {AALU_FRAC_SHIFT{1'b0}}};                                // [RULE4]
        end else begin
            div_num = {{AALU_W{cur_a[AALU_W-1]}}, cur_a};                               // [RULE5]
        end

        next_state            = state;
        next_op_q             = op_q;
        next_dst_q            = dst_q;
        next_src_q            = src_q;
        next_imm_q            = imm_q;
        next_b_q              = b_q;
        next_cnt              = cnt;
        next_busy             = busy;
        next_done             = 1'b0;
        next_op_bytes         = op_bytes;
        next_working_register = working_register;
        next_ram_pointer      = ram_pointer;
        next_flag_sign        = flag_sign;
        next_flag_zero        = flag_zero;
        next_flag_carry       = flag_carry;
        next_flag_overflow    = flag_overflow;
        res                   = cur_a;

        // Held fields follow every accepted op, one-cycle ones too, so they always name the last op
        if (accept) begin
            next_op_q  = cur_op;
            next_dst_q = dst_sel;
            next_src_q = src_sel;
            next_imm_q = imm_sel;
            next_b_q   = cur_b;
        end
        if (accept && !finish) begin
            next_state = AALU_RUN;
            next_cnt   = cyc - 5'h01;
            next_busy  = 1'b1;
        end else if (state == AALU_RUN && !finish) begin
            next_cnt = cnt - 5'h01;
        end

        if (finish) begin
            next_state    = AALU_IDLE;
            next_busy     = 1'b0;
            next_cnt      = '0;
            next_done     = 1'b1;
            next_op_bytes = aalu_bytes(cur_op, cur_imm);
            unique case (cur_op)
                AALU_OP_COMPL:  res = ~cur_a + 24'h000001;                             // [RULE1]
                AALU_OP_DECR: begin
                    res                = cur_a - 24'h000001;                            // [RULE2]
                    next_flag_carry    = (cur_a == 24'h000000);                         // [RULE2]
                    next_flag_overflow = (cur_a == 24'h800000);                         // [RULE2]
                end
                AALU_OP_DECPTR: next_ram_pointer = ram_pointer - PTR_W'(1);            // [RULE3]
                AALU_OP_FDIV:   res = div_q;                                            // [RULE4]
                AALU_OP_DIVMOD: begin
                    res = div_q;                                                        // [RULE5]
                    next_working_register[cur_src] = div_r;                             // [RULE5]
                end
                AALU_OP_XOR:    res = cur_a ^ cur_b;                                    // [RULE6]
                AALU_OP_XNOR:   res = ~(cur_a ^ cur_b);                                 // [RULE8]
            endcase
            // Pointer decrement touches no working register and no flag
            if (cur_op != AALU_OP_DECPTR) begin
                next_working_register[cur_dst] = res;                                   // [RULE10]
                next_flag_sign = res[AALU_W-1];                                         // [RULE1] [RULE6] [RULE8]
                next_flag_zero = (res == '0);                                           // [RULE4] [RULE5]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state            <= AALU_IDLE;
            op_q             <= AALU_OP_COMPL;
            dst_q            <= 2'h0;
            src_q            <= 2'h0;
            imm_q            <= 1'b0;
            b_q              <= '0;
            cnt              <= '0;
            busy             <= 1'b0;
            done             <= 1'b0;
            op_bytes         <= 3'h0;
            working_register <= '0;
            ram_pointer      <= '0;
            flag_sign        <= 1'b0;
            flag_zero        <= 1'b0;
            flag_carry       <= 1'b0;
            flag_overflow    <= 1'b0;
        end else begin
            state            <= next_state;
            op_q             <= next_op_q;
            dst_q            <= next_dst_q;
            src_q            <= next_src_q;
            imm_q            <= next_imm_q;
            b_q              <= next_b_q;
            cnt              <= next_cnt;
            busy             <= next_busy;
            done             <= next_done;
            op_bytes         <= next_op_bytes;
            working_register <= next_working_register;
            ram_pointer      <= next_ram_pointer;
            flag_sign        <= next_flag_sign;
            flag_zero        <= next_flag_zero;
            flag_carry       <= next_flag_carry;
            flag_overflow    <= next_flag_overflow;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_COMPL_RESULT: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
        (accept && op_code == AALU_OP_COMPL) |=> !done ##1
        (done && op_bytes == 3'h2
         && working_register[$past(dst_sel, 2)] == ~$past(working_register[dst_sel], 2) + 24'h000001
         && $stable(flag_carry) && $stable(flag_overflow)))
        else $error("complement result or timing wrong");

    AST_DECR_FLAGS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2]
        (accept && op_code == AALU_OP_DECR) |=>
        (done && working_register[$past(dst_sel)] == $past(working_register[dst_sel]) - 24'h000001
         && flag_carry == ($past(working_register[dst_sel]) == 24'h000000)
         && flag_zero == (working_register[$past(dst_sel)] == 24'h000000)))
        else $error("decrement result or flags wrong");

    AST_DECPTR: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
        (accept && op_code == AALU_OP_DECPTR) |=>
        (done && ram_pointer == $past(ram_pointer) - PTR_W'(1) && $stable(flag_sign)
         && $stable(flag_zero) && $stable(flag_carry) && $stable(flag_overflow)))
        else $error("pointer decrement wrong");

    AST_FDIV_TIME: assert property (@(posedge clk) disable iff (!rst_b) // [RULE4]
        (accept && op_code == AALU_OP_FDIV) |-> ##19 (!done && busy) ##1 (done && !busy))
        else $error("fractional divide not 20 cycles");

    AST_DIV_FLAGS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
        (done && (op_q == AALU_OP_DIVMOD || op_q == AALU_OP_FDIV)) |->
        (flag_sign == working_register[dst_q][AALU_W-1]
         && flag_zero == (working_register[dst_q] == 24'h000000)))
        else $error("division flags do not match result");

    AST_XOR_REG: assert property (@(posedge clk) disable iff (!rst_b) // [RULE6] [RULE7]
        (accept && op_code == AALU_OP_XOR && !imm_sel) |-> ##3
        (done && op_bytes == 3'h2 && working_register[$past(dst_sel, 3)]
         == ($past(working_register[dst_sel], 3) ^ $past(working_register[src_sel], 3))))
        else $error("xor with register wrong");

    AST_XOR_IMM: assert property (@(posedge clk) disable iff (!rst_b) // [RULE7]
        (accept && op_code == AALU_OP_XOR && imm_sel) |-> ##5 !done ##1
        (done && op_bytes == 3'h5
         && working_register[$past(dst_sel, 6)] == ($past(working_register[dst_sel], 6) ^ $past(imm_data, 6))))
        else $error("xor with immediate wrong");

    AST_XNOR: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8] [RULE9]
        (accept && op_code == AALU_OP_XNOR && imm_sel) |-> ##6
        (done && flag_sign == working_register[$past(dst_sel, 6)][AALU_W-1]
         && working_register[$past(dst_sel, 6)] == ~($past(working_register[dst_sel], 6) ^ $past(imm_data, 6))))
        else $error("xnor with immediate wrong");

endmodule : aalu_core
`default_nettype wire

// ==== dv/aalu_seq_model.sv ====
// Sequencer model: issues one operation per request and counts cycles until done.
// Assumes the bench pulses req for one clock while finished is low.
`timescale 1ns/10ps
`default_nettype none
module aalu_seq_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Bench side
    input  wire logic        req,
    input  wire logic [2:0]  req_code,
    input  wire logic [1:0]  req_dst,
    input  wire logic [1:0]  req_src,
    input  wire logic        req_imm_sel,
    input  wire logic [23:0] req_imm,
    output logic [5:0]       cycles,
    output logic             finished,
    // Datapath side
    input  wire logic        busy,
    input  wire logic        done,
    output logic             op_valid,
    output logic [2:0]       op_code,
    output logic [1:0]       dst_sel,
    output logic [1:0]       src_sel,
    output logic             imm_sel,
    output logic [23:0]      imm_data
);
    logic [2:0]  code_q;
    logic [1:0]  dst_q;
    logic [1:0]  src_q;
    logic        sel_q;
    logic [23:0] imm_q;
    logic        running;
    // Fields read as the inverse outside a request, so stale values cannot pass
    assign op_code  = op_valid ? code_q : ~code_q;
    assign dst_sel  = op_valid ? dst_q : ~dst_q;
    assign src_sel  = op_valid ? src_q : ~src_q;
    assign imm_sel  = op_valid ? sel_q : ~sel_q;
    assign imm_data = op_valid ? imm_q : ~imm_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {op_valid, running, finished, cycles} <= '0;
            {code_q, dst_q, src_q, sel_q, imm_q}  <= '0;
        end else begin
            finished <= 1'b0;
            if (op_valid) begin
                op_valid <= 1'b0;
                cycles   <= 6'h01;
            end else if (running) begin
                if (done) begin
                    running  <= 1'b0;
                    finished <= 1'b1;
                end else begin
                    cycles <= cycles + 6'h01;
                end
            end else if (req && !busy) begin
                op_valid <= 1'b1;
                running  <= 1'b1;
                {code_q, dst_q, src_q, sel_q, imm_q} <= {req_code, req_dst, req_src, req_imm_sel, req_imm};
            end
        end
    end
endmodule : aalu_seq_model
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the accumulator datapath, driven through the sequencer model.
// Assumes a 20 MHz clock; registers are loaded by xor with an immediate since none load directly.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import aalu_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req = 1'b0;
    logic [2:0] r_code = 3'h0;
    logic [1:0] r_dst = 2'h0;
    logic [1:0] r_src = 2'h0;
    logic r_sel = 1'b0;
    logic [23:0] r_imm = 24'h0;
    logic [5:0] cycles;
    logic finished, busy, done, op_valid, imm_sel, flag_sign, flag_zero, flag_carry, flag_overflow;
    logic [2:0] op_code, op_bytes;
    logic [1:0] dst_sel, src_sel;
    logic [23:0] imm_data;
    logic [AALU_NREG-1:0][AALU_W-1:0] working_register;
    logic [7:0] ram_pointer;
    logic [23:0] mr [4];
    logic [3:0] ef = 4'h0;
    int errors = 0;
    int n_tests = 0;
    int tick = 0;
    always #25 clk = ~clk;
    aalu_seq_model i_seq (.clk(clk), .rst_b(rst_b), .req(req), .req_code(r_code), .req_dst(r_dst),
        .req_src(r_src), .req_imm_sel(r_sel), .req_imm(r_imm), .cycles(cycles), .finished(finished),
        .busy(busy), .done(done), .op_valid(op_valid), .op_code(op_code), .dst_sel(dst_sel),
        .src_sel(src_sel), .imm_sel(imm_sel), .imm_data(imm_data));
    aalu_core #(.PTR_W(8)) i_dut (.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
        .dst_sel(dst_sel), .src_sel(src_sel), .imm_sel(imm_sel), .imm_data(imm_data), .busy(busy),
        .done(done), .op_bytes(op_bytes), .working_register(working_register), .ram_pointer(ram_pointer),
        .flag_sign(flag_sign), .flag_zero(flag_zero), .flag_carry(flag_carry), .flag_overflow(flag_overflow));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    // Sign and zero follow the destination; carry and overflow keep what the caller set
    function automatic void set_sz(input int d);
        ef[3] = mr[d][23];
        ef[2] = (mr[d] == 24'h0);
    endfunction : set_sz
    task automatic do_op(input logic [2:0] c, input logic [1:0] d, input logic [1:0] s, input logic i,
                         input logic [23:0] v, input logic [5:0] ncyc, input logic [2:0] nbyt);
        int k;
        int nb;
        nb = 0;
        @(posedge clk);
        {req, r_code, r_dst, r_src, r_sel, r_imm} <= {1'b1, c, d, s, i, v};
        @(posedge clk);
        req <= 1'b0;
        for (k = 0; k < 60 && finished !== 1'b1; k++) begin
            @(posedge clk);
            #1;
            // Busy stands from the accept edge up to the edge that writes the result
            if (busy === 1'b1) nb++;
        end
        check(24'(cycles), 24'(ncyc), "cycles");
        check(24'(nb), 24'(ncyc - 6'h01), "busy cycles");
        check(24'(op_bytes), 24'(nbyt), "bytes");
        for (k = 0; k < 4; k++) check(working_register[k], mr[k], "register");
        check(24'({flag_sign, flag_zero, flag_carry, flag_overflow}), 24'(ef), "flags");
    endtask : do_op
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int k = 0; k < AALU_NREG; k++) check(working_register[k], 24'h0, "reset registers");
        check({7'h0, ram_pointer, op_bytes, busy, done, flag_sign, flag_zero, flag_carry, flag_overflow}, 24'h0, "reset");
    endtask : t_reset
    task automatic t_load();
        logic [23:0] v [4] = '{24'h100000, 24'h400000, 24'hfffff9, 24'h000002};
        for (int k = 0; k < 4; k++) begin
            mr[k] = mr[k] ^ v[k];
            set_sz(k);
            do_op(AALU_OP_XOR, k[1:0], 2'h0, 1'b1, v[k], 6'h06, 3'h5);
        end
    endtask : t_load
    task automatic t_logic();
        mr[0] = mr[0] ^ mr[3];
        set_sz(0);
        do_op(AALU_OP_XOR, 2'h0, 2'h3, 1'b0, 24'h0, 6'h03, 3'h2);
        mr[0] = ~(mr[0] ^ mr[3]);
        set_sz(0);
        do_op(AALU_OP_XNOR, 2'h0, 2'h3, 1'b0, 24'h0, 6'h03, 3'h2);
        mr[0] = ~(mr[0] ^ 24'h100000);
        set_sz(0);
        do_op(AALU_OP_XNOR, 2'h0, 2'h1, 1'b1, 24'h100000, 6'h06, 3'h5);
        check(flag_zero, 1'b1, "xnor to zero");
        mr[0] = 24'h100000;
        set_sz(0);
        do_op(AALU_OP_XOR, 2'h0, 2'h2, 1'b1, 24'h100000, 6'h06, 3'h5);
    endtask : t_logic
    task automatic t_div();
        logic signed [47:0] a;
        logic signed [47:0] q;
        int x;
        int y;
        a = $signed({{24{mr[0][23]}}, mr[0]}) <<< 24;
        q = a / $signed({{24{mr[1][23]}}, mr[1]});
        mr[0] = q[23:0];
        set_sz(0);
        do_op(AALU_OP_FDIV, 2'h0, 2'h1, 1'b0, 24'h0, 6'h14, 3'h2);
        check(working_register[0], 24'h400000, "fraction");
        x = $signed(mr[2]);
        y = $signed(mr[3]);
        mr[2] = x / y;
        mr[3] = x % y;
        set_sz(2);
        do_op(AALU_OP_DIVMOD, 2'h2, 2'h3, 1'b0, 24'h0, 6'h14, 3'h2);
    endtask : t_div
    task automatic t_decr();
        mr[1] = 24'h0;
        set_sz(1);
        do_op(AALU_OP_XOR, 2'h1, 2'h1, 1'b0, 24'h0, 6'h03, 3'h2);
        mr[1] = 24'hffffff;
        ef = 4'b1010;
        do_op(AALU_OP_DECR, 2'h1, 2'h0, 1'b0, 24'h0, 6'h01, 3'h1);
        mr[1] = 24'h800000;
        set_sz(1);
        do_op(AALU_OP_XOR, 2'h1, 2'h0, 1'b1, 24'h7fffff, 6'h06, 3'h5);
        mr[1] = 24'h7fffff;
        ef = 4'b0001;
        do_op(AALU_OP_DECR, 2'h1, 2'h0, 1'b0, 24'h0, 6'h01, 3'h1);
    endtask : t_decr
    task automatic t_compl();
        mr[2] = ~mr[2] + 24'h1;
        set_sz(2);
        do_op(AALU_OP_COMPL, 2'h2, 2'h0, 1'b0, 24'h0, 6'h02, 3'h2);
    endtask : t_compl
    task automatic t_ptr();
        do_op(AALU_OP_DECPTR, 2'h0, 2'h0, 1'b0, 24'h0, 6'h01, 3'h1);
        check(ram_pointer, 8'hff, "pointer wrap");
        do_op(AALU_OP_DECPTR, 2'h3, 2'h1, 1'b1, 24'h0, 6'h01, 3'h1);
        check(ram_pointer, 8'hfe, "pointer");
    endtask : t_ptr
    ////////////////////////////////////////////////////////////////////////////
    // Whole sequence needs about 170 cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        tick++;
        if (tick == 4000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        for (int k = 0; k < 4; k++) mr[k] = 24'h0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        t_reset();
        t_load();
        t_logic();
        t_div();
        t_decr();
        t_compl();
        t_ptr();
        summarize();
    end
endmodule : testbench
`default_nettype wire
